// ---- inc/serial_port_pkg.sv ----
// Shared constants and carriers for the full-duplex serial port pins.
// Assumes a single system clock domain; link clocks are sampled inputs.
package serial_port_pkg;
  localparam int          WORD_BITS      = 16;
  localparam int          BYTE_BITS      = 8;
  localparam int          CNT_W          = 5;
  localparam logic [4:0]  WORD_COUNT     = 5'h10;
  localparam logic [4:0]  BYTE_COUNT     = 5'h08;
  localparam logic [15:0] SHIFT_RST      = 16'h0000;
  localparam logic [4:0]  CNT_RST        = 5'h00;
  localparam int          SYNC_STAGES    = 2;
  // Edge detector history taken after the synchroniser
  localparam logic [1:0]  EDGE_RST       = 2'h3;

  typedef struct packed {
    logic bit_clock;
    logic frame_sync;
    logic data;
  } link_in_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } rx_word_t;

  function automatic logic [4:0] bits_for_mode(input logic byte_mode);
    bits_for_mode = byte_mode ? BYTE_COUNT : WORD_COUNT;
  endfunction
endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser with edge detection on the synchronised level.
// Assumes input is asynchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;
endmodule // pin_sync
`default_nettype wire

// ---- src/serial_port_pins.sv ----
// Full-duplex serial port: receive and transmit shift paths on pins.
// Assumes link clocks are far slower than sys_clk (several samples a bit).
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Receive shifts on external receive clock
// - Transmit shifts on external transmit clock
// - Serial output driven only while shifting
// - Receive frame-sync falling edge starts receive
// - Transmit frame-sync falling edge starts transmit while sync-out select is low
// - Transmit frame-sync is input while sync-out select is low
// - Sync-out select drives frame-sync, self-generated
// - Independent receive and transmit paths concurrently
// - Byte or word length by mode
module serial_port_pins (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        rx_bit_clock,
  input  wire logic        rx_frame_sync,
  input  wire logic        serial_in_pin,
  input  wire logic        tx_bit_clock,
  input  wire logic        tx_frame_sync_in,
  output logic             tx_frame_sync_out,
  output logic             tx_frame_sync_oe,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  input  wire logic        byte_mode,
  input  wire logic        tx_sync_out_select,
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_load,
  output logic             tx_ready,
  output logic [15:0]      rx_data,
  output logic             rx_valid,
  output logic             tx_done
);
  logic [4:0] lvl, rise, fall;

  pin_sync #(.WIDTH(5)) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({rx_bit_clock,
                rx_frame_sync,
                serial_in_pin,
                tx_bit_clock,
                tx_frame_sync_in}),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall)
  );

  wire logic rclk_fall = fall[4];
  wire logic rfs_fall  = fall[3];
  wire logic rdat      = lvl[2];
  wire logic xclk_rise = rise[1];
  wire logic xfs_fall  = fall[0];

  // Counts stop at 16, so the 5-bit sum never wraps
  function automatic logic [4:0] cnt_inc(input logic [4:0] c);
    cnt_inc = c + 5'h01;
  endfunction

  // Receive path
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} rx_state_t;
  rx_state_t   rx_st_r, rx_st_nxt;
  logic [15:0] rx_shift_reg_r, rx_shift_reg_nxt;
  logic [4:0]  rx_cnt_r, rx_cnt_nxt;
  logic [4:0]  rx_len_r, rx_len_nxt;
  serial_port_pkg::rx_word_t rx_out_r, rx_out_nxt;

  always_comb begin
    rx_st_nxt        = rx_st_r;
    rx_shift_reg_nxt = rx_shift_reg_r;
    rx_cnt_nxt       = rx_cnt_r;
    rx_len_nxt       = rx_len_r;
    rx_out_nxt       = rx_out_r;
    rx_out_nxt.valid = 1'b0;
    unique case (rx_st_r)
      RX_IDLE: begin
        if (rfs_fall) begin
          rx_st_nxt  = RX_SHIFT;
          rx_cnt_nxt = serial_port_pkg::CNT_RST;
          // Length fixed per frame; a mode flip mid-frame waits
          rx_len_nxt = serial_port_pkg::bits_for_mode(byte_mode);
        end
      end
      RX_SHIFT: begin
        // Sample data on falling receive clock edge
        if (rclk_fall) begin
          rx_shift_reg_nxt = {rx_shift_reg_r[14:0], rdat};
          rx_cnt_nxt       = cnt_inc(rx_cnt_r);
          if (cnt_inc(rx_cnt_r) == rx_len_r) begin
            rx_st_nxt        = RX_IDLE;
            rx_out_nxt.valid = 1'b1;
            rx_out_nxt.data  = (rx_len_r == serial_port_pkg::BYTE_COUNT) ?
              {8'h00, rx_shift_reg_r[6:0], rdat} :
              {rx_shift_reg_r[14:0], rdat};
          end
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_st_r        <= RX_IDLE;
      rx_shift_reg_r <= serial_port_pkg::SHIFT_RST;
      rx_cnt_r       <= serial_port_pkg::CNT_RST;
      rx_len_r       <= serial_port_pkg::WORD_COUNT;
      rx_out_r       <= '0;
    end else begin
      rx_st_r        <= rx_st_nxt;
      rx_shift_reg_r <= rx_shift_reg_nxt;
      rx_cnt_r       <= rx_cnt_nxt;
      rx_len_r       <= rx_len_nxt;
      rx_out_r       <= rx_out_nxt;
    end
  end

  assign rx_data  = rx_out_r.data;
  assign rx_valid = rx_out_r.valid;

  // Transmit path, independent of receive
  typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SHIFT} tx_state_t;
  tx_state_t   tx_st_r, tx_st_nxt;
  logic [15:0] tx_shift_reg_r, tx_shift_reg_nxt;
  logic [4:0]  tx_cnt_r, tx_cnt_nxt;
  logic [4:0]  tx_len_r, tx_len_nxt;
  logic        dout_r, dout_nxt;
  logic        dout_oe_r, dout_oe_nxt;
  logic        fs_out_r, fs_out_nxt;
  logic        done_r, done_nxt;
  logic        start_tx;

  // Internal sync pulse: low for one transmit clock when armed
  always_comb begin
    start_tx = tx_sync_out_select ? (fs_out_r == 1'b0 && xclk_rise)
                                  : xfs_fall;
  end

  always_comb begin
    tx_st_nxt        = tx_st_r;
    tx_shift_reg_nxt = tx_shift_reg_r;
    tx_cnt_nxt       = tx_cnt_r;
    tx_len_nxt       = tx_len_r;
    dout_nxt         = dout_r;
    dout_oe_nxt      = dout_oe_r;
    fs_out_nxt       = fs_out_r;
    done_nxt         = 1'b0;
    unique case (tx_st_r)
      TX_IDLE: begin
        dout_oe_nxt = 1'b0;
        fs_out_nxt  = 1'b1;
        if (tx_load) begin
          tx_shift_reg_nxt = byte_mode ? {tx_data[7:0], 8'h00} : tx_data;
          // Length fixed at load, together with the shift word
          tx_len_nxt       = serial_port_pkg::bits_for_mode(byte_mode);
          tx_st_nxt        = TX_ARMED;
        end
      end
      TX_ARMED: begin
        if (tx_sync_out_select && xclk_rise && fs_out_r) begin
          fs_out_nxt = 1'b0;
        end
        if (start_tx) begin
          tx_st_nxt  = TX_SHIFT;
          tx_cnt_nxt = serial_port_pkg::CNT_RST;
          fs_out_nxt = 1'b1;
        end
      end
      TX_SHIFT: begin
        // New bit presented on rising transmit clock edge
        if (xclk_rise) begin
          if (tx_cnt_r == tx_len_r) begin
            tx_st_nxt   = TX_IDLE;
            dout_oe_nxt = 1'b0;
            done_nxt    = 1'b1;
          end else begin
            dout_nxt         = tx_shift_reg_r[15];
            dout_oe_nxt      = 1'b1;
            tx_shift_reg_nxt = {tx_shift_reg_r[14:0], 1'b0};
            tx_cnt_nxt       = cnt_inc(tx_cnt_r);
          end
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_st_r        <= TX_IDLE;
      tx_shift_reg_r <= serial_port_pkg::SHIFT_RST;
      tx_cnt_r       <= serial_port_pkg::CNT_RST;
      tx_len_r       <= serial_port_pkg::WORD_COUNT;
      dout_r         <= 1'b0;
      dout_oe_r      <= 1'b0;
      fs_out_r       <= 1'b1;
      done_r         <= 1'b0;
    end else begin
      tx_st_r        <= tx_st_nxt;
      tx_shift_reg_r <= tx_shift_reg_nxt;
      tx_cnt_r       <= tx_cnt_nxt;
      tx_len_r       <= tx_len_nxt;
      dout_r         <= dout_nxt;
      dout_oe_r      <= dout_oe_nxt;
      fs_out_r       <= fs_out_nxt;
      done_r         <= done_nxt;
    end
  end

  // Output enable follows the sync-out select, so the pin is an input only while select is low
  assign tx_frame_sync_oe  = tx_sync_out_select;
  assign tx_frame_sync_out = fs_out_r;
  assign serial_out_pin    = dout_r;
  assign serial_out_oe     = dout_oe_r;
  assign tx_ready          = (tx_st_r == TX_IDLE);
  assign tx_done           = done_r;
endmodule // serial_port_pins
`default_nettype wire

// ---- tb/serial_port_monitor.sv ----
// Checker on the serial port top ports.
// Assumes one domain, sys_clk, sync srst.
`timescale 1ns/1ns
`default_nettype none
module serial_port_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic tx_load,
  input wire logic tx_ready,
  input wire logic tx_sync_out_select,
  input wire logic tx_frame_sync_oe,
  input wire logic tx_frame_sync_out,
  input wire logic serial_out_oe,
  input wire logic rx_valid,
  input wire logic tx_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_FS_OE:
  assert property (tx_frame_sync_oe == tx_sync_out_select) else $error("fs oe");
  AST_OUT_IDLE:
  assert property (tx_ready |-> !serial_out_oe) else $error("idle drive");
  AST_FS_IDLE:
  assert property (tx_ready |-> tx_frame_sync_out) else $error("fs idle");
  AST_RXV_PULSE:
  assert property (rx_valid |=> !rx_valid) else $error("rx_valid long");
  AST_DONE_PULSE:
  assert property (tx_done |=> !tx_done) else $error("tx_done long");
  AST_DONE_OE:
  assert property (tx_done |-> $fell(serial_out_oe)) else $error("done oe");
  AST_LOAD:
  assert property (tx_ready && tx_load |=> !tx_ready) else $error("load");
  AST_OE_END:
  assert property ($fell(serial_out_oe) |-> tx_done && tx_ready ##1 !tx_done)
    else $error("oe end");
  AST_FS_PULSE:
  assert property ($fell(tx_frame_sync_out) |->
                   tx_sync_out_select && !tx_ready) else $error("fs pulse");
endmodule // serial_port_monitor
bind serial_port_pins serial_port_monitor mon_u (.sys_clk, .srst, .tx_load,
  .tx_ready, .tx_sync_out_select, .tx_frame_sync_oe, .tx_frame_sync_out,
  .serial_out_oe, .rx_valid, .tx_done);
`default_nettype wire

// ---- tb/codec_model.sv ----
// Behavioural codec at the far side of the port.
// Assumes the bench calls its frame tasks.
`timescale 1ns/1ns
`default_nettype none
module codec_model (
  output logic     rx_bit_clock,
  output logic     rx_frame_sync,
  output logic     serial_in_pin,
  output logic     tx_bit_clock,
  output logic     fsx_drive,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe
);
  // Clocks stand high between frames
  initial begin
    rx_bit_clock = 1'b1;
    rx_frame_sync = 1'b1;
    serial_in_pin = 1'b0;
    tx_bit_clock = 1'b1;
    fsx_drive = 1'b1;
  end
  task automatic rx_frame(input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      rx_frame_sync = (i != 0);
      serial_in_pin = d[n-1-i];
      #160 rx_bit_clock = 1'b0;
      #160 rx_bit_clock = 1'b1;
    end
    rx_frame_sync = 1'b1;
    // Stale bit inverted so a late sample shows
    serial_in_pin = ~serial_in_pin;
  endtask
  task automatic tx_frame(input logic ext, input int n,
                          output logic [15:0] got);
    got = 16'h0000;
    for (int i = 0; i < n + 4; i++) begin
      fsx_drive = !(ext && i == 0);
      #160 tx_bit_clock = 1'b0;
      #140;
      if (serial_out_oe === 1'b1) got = {got[14:0], serial_out_pin};
      #20 tx_bit_clock = 1'b1;
    end
    fsx_drive = 1'b1;
  endtask
endmodule // codec_model
`default_nettype wire

// ---- tb/serial_port_pins_bench.sv ----
// Self-checking bench for the serial port pins.
// Assumes the monitor binds itself to the design.
`timescale 1ns/1ns
`default_nettype none
module serial_port_pins_bench;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        byte_mode = 1'b0;
  logic        tx_sync_out_select = 1'b0;
  logic        tx_load = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic [15:0] rx_got, tg, td, rd;
  logic [31:0] seed = 32'hC371;
  int          fails = 0, n_tests = 0, cyc = 0, n_rxv, n_done, n;
  wire logic   rx_bit_clock, rx_frame_sync, serial_in_pin, tx_bit_clock;
  wire logic   fsx_drive, tx_frame_sync_out, tx_frame_sync_oe;
  wire logic   serial_out_pin, serial_out_oe, tx_ready, rx_valid, tx_done;
  wire logic [15:0] rx_data;
  wire logic   tx_frame_sync_in =
    tx_frame_sync_oe ? tx_frame_sync_out : fsx_drive;
  serial_port_pins dut_u (.sys_clk, .srst, .rx_bit_clock, .rx_frame_sync,
    .serial_in_pin, .tx_bit_clock, .tx_frame_sync_in, .tx_frame_sync_out,
    .tx_frame_sync_oe, .serial_out_pin, .serial_out_oe, .byte_mode,
    .tx_sync_out_select, .tx_data, .tx_load, .tx_ready, .rx_data,
    .rx_valid, .tx_done);
  codec_model pm (.rx_bit_clock, .rx_frame_sync, .serial_in_pin,
    .tx_bit_clock, .fsx_drive, .serial_out_pin, .serial_out_oe);
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] fit(input logic [15:0] d, input int b);
    return (b == 8) ? {8'h00, d[7:0]} : d;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("%0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) n_rxv++;
    if (rx_valid === 1'b1) rx_got = rx_data;
    if (tx_done === 1'b1) n_done++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    check({15'h0, serial_out_oe}, 16'h0000);
    check({15'h0, tx_frame_sync_oe}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      td = (i == 0) ? 16'h8001 : seed[15:0];
      rd = (i == 1) ? 16'h00FF : seed[31:16];
      byte_mode = i[0];
      tx_sync_out_select = i[1];
      n = i[0] ? 8 : 16;
      n_rxv = 0;
      n_done = 0;
      tx_data = td;
      tx_load = 1'b1;
      @(negedge sys_clk);
      // Busy now, so this second word must be ignored
      tx_data = ~td;
      @(negedge sys_clk);
      tx_load = 1'b0;
      fork
        pm.rx_frame(rd, n);
        pm.tx_frame(!i[1], n, tg);
      join
      repeat (8) @(negedge sys_clk);
      check(tg, fit(td, n));
      check(rx_got, fit(rd, n));
      check(n_rxv[15:0], 16'h0001);
      check(n_done[15:0], 16'h0001);
      check({15'h0, tx_frame_sync_oe}, {15'h0, i[1]});
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule // serial_port_pins_bench
`default_nettype wire
